//--- tile_pkg.sv
/*
 * Shared constants and types of the programmable logic tile: register byte
 * offsets, field positions, reset values and the state record.
 * Assumes a single AHB-Lite slave port with 32-bit data.
 */
`default_nettype none
package tile_pkg;
    // Tile geometry
    localparam int NUM_CELLS = 8;
    localparam int NUM_GLOBAL_DRIVE_BUFFER = 8;
    localparam int NUM_SLOTS = 4;
    // Byte offsets of the registers (low address byte)
    localparam logic [7:0] OFS_TILE_CTRL = 8'h00;
    localparam logic [7:0] OFS_LUT_SLOTS = 8'h04;
    localparam logic [7:0] OFS_PIN_CTRL = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_CELL_BASE = 8'h20;
    // Tile control fields
    localparam int CB_CONFIG = 0;
    localparam int CB_SR_ASYNC = 1;
    localparam int CB_SR_USED = 2;
    localparam int CB_CE_USED = 3;
    localparam int CB_SR_FABRIC = 4;
    localparam int CB_CE_FABRIC = 5;
    localparam int CB_SR_PAIR = 6;
    localparam int CB_CE_PAIR = 8;
    localparam int CB_CLK_FABRIC = 10;
    localparam int CB_CLK_GLOBAL_DRIVE_BUFFER = 11;
    localparam int CTRL_W = 14;
    localparam logic [13:0] CTRL_RST = 14'h0001;
    // Cell configuration fields
    localparam int CF_REG_OUT = 16;
    localparam int CF_CARRY = 17;
    localparam int CF_GLOBAL = 18;
    localparam int CF_SET = 19;
    localparam int CELL_W = 20;
    localparam logic [19:0] CELL_RST = 20'h00000;
    localparam logic [11:0] SLOTS_RST = 12'h000;
    localparam logic [15:0] PIN_RST = 16'h0000;
    // Status fields
    localparam int SB_Q = 8;
    localparam int SB_PIN = 16;
    localparam int SB_CARRY = 24;

    // Bus transfer phase
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_WAIT = 2'b01,
        PH_DONE = 2'b10
    } phase_type;

    // Whole state of the tile
    typedef struct packed {
        phase_type phase;
        logic wr;
        logic [7:0] addr;
        logic [31:0] rdata;
        logic [13:0] ctrl;
        logic [11:0] slots;
        logic [15:0] pin_ctrl;
        logic [7:0][19:0] cell_cfg;
        logic [7:0] q;
        logic clk_prev;
    } state_type;
endpackage
`default_nettype wire

//--- logic_tile.sv
/*
 * Programmable logic tile: eight logic cells with lookup, carry and
 * flip-flop, shared clock/enable/set-reset selected from global buffers
 * or fabric, global reset and pin float during configuration, and an
 * AHB-Lite register slave for all configuration.
 * Assumes every input is synchronous to hclk; the tile clock is an
 * edge of the selected source seen by hclk sampling.
 */
// Notes on behaviour
// - eight cells, each lookup plus register
// - lookup is a sixteen-entry one-bit table
// - enable and set/reset may go unused
// - one clock enable for all cells
// - shared set/reset, async or sync
// - clock from global buffer or fabric
// - output is lookup or registered value
// - fast carry in and out chain
// - unused set/reset never touches flip-flops
// - global reset held during configuration
// - wake-up state is always reset
// - any global buffer may clock tile
// - at most four buffers reach lookups
// - even buffers reset, odd buffers enable
// - pins float during configuration
// - unused clock pins serve as I/O
`timescale 1ns/1ps
`default_nettype none
module logic_tile (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [7:0] global_input_pin,
    output logic [7:0] global_pin_out,
    output logic [7:0] global_pin_oe_n,
    output logic io_float_control,
    input wire logic fabric_clk,
    input wire logic fabric_ce,
    input wire logic fabric_sr,
    input wire logic [31:0] cell_data_in,
    input wire logic carry_chain_input,
    output logic carry_chain_output,
    output logic [7:0] cell_out
);
    import tile_pkg::*;

    state_type st_ff; // Registered state
    state_type nxt_st; // Next state
    logic [7:0] global_drive_buffer; // Global buffer levels
    logic clk_src; // Selected tile clock source
    logic tick; // Rising edge of tile clock
    logic sr_lvl; // Selected set/reset level
    logic ce_lvl; // Selected clock enable level
    logic sr_act; // Set/reset in force
    logic ce_ok; // Enabled tile edge
    logic cfg_on; // Configuration in progress
    logic [3:0] slot_lvl; // Global levels offered to lookups
    logic [8:0] carry; // Carry chain nodes
    logic [7:0] lut_out; // Lookup results
    logic [7:0] rst_val; // Set or reset value per cell
    logic [7:0] used_clk; // Pin feeds the clock net

    assign global_drive_buffer = global_input_pin;
    assign cfg_on = st_ff.ctrl[CB_CONFIG];

    assign clk_src = st_ff.ctrl[CB_CLK_FABRIC] ? fabric_clk
                   : global_drive_buffer[st_ff.ctrl[CB_CLK_GLOBAL_DRIVE_BUFFER +: 3]];
    assign tick = clk_src & ~st_ff.clk_prev;

    assign sr_lvl = st_ff.ctrl[CB_SR_FABRIC] ? fabric_sr
                  : global_drive_buffer[{st_ff.ctrl[CB_SR_PAIR +: 2], 1'b0}];
    assign ce_lvl = st_ff.ctrl[CB_CE_FABRIC] ? fabric_ce
                  : global_drive_buffer[{st_ff.ctrl[CB_CE_PAIR +: 2], 1'b1}];

    assign sr_act = st_ff.ctrl[CB_SR_USED] & sr_lvl;
    assign ce_ok = tick & (~st_ff.ctrl[CB_CE_USED] | ce_lvl);

    // four global slots
    // Only four slot selects exist, so no tile sees more than four
    // distinct buffers on its lookup inputs.
    genvar s;
    generate
        for (s = 0; s < NUM_SLOTS; s++) begin : g_slot
            assign slot_lvl[s] = global_drive_buffer[st_ff.slots[3*s +: 3]];
        end
    endgenerate

    assign carry[0] = carry_chain_input;
    assign carry_chain_output = carry[NUM_CELLS];

    // Per-cell lookup, carry and output
    genvar k;
    generate
        for (k = 0; k < NUM_CELLS; k++) begin : g_cell
            logic [19:0] cfg; // This cell's configuration
            logic [3:0] idx; // Lookup address
            assign cfg = st_ff.cell_cfg[k];
            assign idx = {cfg[CF_CARRY] ? carry[k] : cell_data_in[4*k+3],
                          cell_data_in[4*k+2],
                          cell_data_in[4*k+1],
                          cfg[CF_GLOBAL] ? slot_lvl[k % NUM_SLOTS]
                                         : cell_data_in[4*k]};
            assign lut_out[k] = cfg[idx];
            assign carry[k+1] = (idx[1] & idx[2]) | ((idx[1] | idx[2]) & carry[k]);
            assign cell_out[k] = cfg[CF_REG_OUT] ? st_ff.q[k] : lut_out[k];
            assign rst_val[k] = cfg[CF_SET];
            assign used_clk[k] = ~st_ff.ctrl[CB_CLK_FABRIC]
                               & (st_ff.ctrl[CB_CLK_GLOBAL_DRIVE_BUFFER +: 3] == 3'(k));
        end
    endgenerate

    assign global_pin_out = st_ff.pin_ctrl[7:0];
    assign global_pin_oe_n = ~(st_ff.pin_ctrl[15:8] & ~used_clk & {8{~cfg_on}});
    assign io_float_control = cfg_on;

    // Bus answers: one wait state per transfer, always OKAY
    assign hreadyout = (st_ff.phase != PH_WAIT);
    assign hresp = 1'b0;
    assign hrdata = st_ff.rdata;

    // Next-state logic: bus slave, configuration writes, cell registers
    always_comb begin
        logic [4:0] ci; // Cell register index from address
        ci = 5'(st_ff.addr[6:2] - 5'(OFS_CELL_BASE >> 2));
        nxt_st = st_ff;
        nxt_st.clk_prev = clk_src;

        // Bus phase tracking
        unique case (st_ff.phase)
            PH_WAIT: begin
                nxt_st.phase = PH_DONE;
                nxt_st.rdata = 32'h0000_0000;
                if (st_ff.wr) begin
                    // Writes land in the first data cycle
                    if (st_ff.addr == OFS_TILE_CTRL) begin
                        nxt_st.ctrl = hwdata[CTRL_W-1:0];
                    end else if (st_ff.addr == OFS_LUT_SLOTS) begin
                        nxt_st.slots = hwdata[11:0];
                    end else if (st_ff.addr == OFS_PIN_CTRL) begin
                        nxt_st.pin_ctrl = hwdata[15:0];
                    end else if (st_ff.addr >= OFS_CELL_BASE && ci < 5'(NUM_CELLS)) begin
                        nxt_st.cell_cfg[ci[2:0]] = hwdata[CELL_W-1:0];
                    end
                end else begin
                    // Read data registered for the ready cycle
                    if (st_ff.addr == OFS_TILE_CTRL) begin
                        nxt_st.rdata = {18'h00000, st_ff.ctrl};
                    end else if (st_ff.addr == OFS_LUT_SLOTS) begin
                        nxt_st.rdata = {20'h00000, st_ff.slots};
                    end else if (st_ff.addr == OFS_PIN_CTRL) begin
                        nxt_st.rdata = {16'h0000, st_ff.pin_ctrl};
                    end else if (st_ff.addr == OFS_STATUS) begin
                        nxt_st.rdata[7:0] = cell_out;
                        nxt_st.rdata[SB_Q +: 8] = st_ff.q;
                        nxt_st.rdata[SB_PIN +: 8] = global_input_pin;
                        nxt_st.rdata[SB_CARRY] = carry[NUM_CELLS];
                    end else if (st_ff.addr >= OFS_CELL_BASE && ci < 5'(NUM_CELLS)) begin
                        nxt_st.rdata = {12'h000, st_ff.cell_cfg[ci[2:0]]};
                    end
                end
            end
            PH_IDLE, PH_DONE: begin
                nxt_st.phase = PH_IDLE;
                if (hsel && htrans[1] && hready) begin
                    // Address phase taken; low byte decodes, upper bits mirror
                    nxt_st.phase = PH_WAIT;
                    nxt_st.wr = hwrite;
                    nxt_st.addr = {haddr[7:2], 2'b00};
                end
            end
            default: begin
                nxt_st.phase = PH_IDLE;
            end
        endcase

        // Cell flip-flops; async reset acts at the next hclk edge,
        // the finest the single-clock model can resolve.
        if (cfg_on) begin
            nxt_st.q = 8'h00;
        end else if (sr_act && st_ff.ctrl[CB_SR_ASYNC]) begin
            nxt_st.q = rst_val;
        end else if (ce_ok) begin
            nxt_st.q = sr_act ? rst_val : lut_out;
        end
    end

    // Working notes for whoever picks this block up next.
    //
    // Tile clock
    // The tile clock is not a real clock net here. The selected source
    // is sampled by hclk and a rising edge is seen as low at one hclk
    // edge and high at the next. A source must therefore stay low and
    // high for at least one hclk period each, or its edge is lost.
    // This keeps the whole block in one domain, at the price of a
    // maximum tile clock rate of half the bus clock.
    //
    // Switching the source
    // When the source select is rewritten, clk_prev still holds the old
    // source's level. If the old source was low and the new one is high,
    // one false edge is seen. Software should park both sources low, or
    // hold the enable off, while it changes the selection.
    //
    // Clock enable
    // The shared enable only gates the tile edge; it never reaches the
    // bus logic. With the enable unused, every tile edge loads all eight
    // registers. With it used and low, all eight hold together, and a
    // synchronous set/reset waits for the next enabled edge as well.
    //
    // Set/reset
    // Asynchronous set/reset cannot act between hclk edges in a model
    // with one clock, so it acts at the next hclk edge whatever the tile
    // clock does. Each cell chooses set or reset through its own bit;
    // the control itself is shared by the tile. With the control unused
    // the registers are only ever cleared by the configuration bit or by hresetn.
    //
    // Configuration
    // The configuration bit stands for the device's load phase. While it
    // is set, all registers are held at zero and every user pin floats,
    // whatever the pin control register says. Clearing it is the only
    // way out; the bit resets to one, so a tile wakes up floating.
    //
    // Global buffers
    // Buffer levels are taken straight from the global input pins. Only
    // even buffers reach set/reset and only odd ones reach the enable;
    // the pair field picks which of the four. Any buffer may clock the
    // tile. Four slot selects feed lookup inputs, so no tile ever sees
    // more than four distinct buffers there, though two slots may name
    // the same buffer.
    //
    // Pins
    // A pin that is the current clock source cannot be driven; its
    // enable is forced off even if software asks for it. Other pins
    // follow the pin control register once configuration has ended.
    // The enable is active low, so all ones means every pin floats.
    //
    // Carry chain
    // Each cell forwards the majority of i1, i2 and its carry in. The
    // chain is purely combinational across all eight cells, so a long
    // cascade of tiles adds its delay to the hclk path; keep chains short
    // when the bus clock is fast.
    //
    // Bus
    // Every transfer takes exactly one wait cycle. Writes land in that
    // wait cycle, so a read straight after a write already sees the new
    // value. Read data is registered and stands until the next transfer
    // has ended its wait cycle. Only the low address byte decodes; higher
    // address bits alias. Unmapped reads return zero and unmapped writes
    // are dropped, both with an OKAY response.
    //
    // Status
    // The status word is a snapshot taken in the wait cycle. Lookup
    // outputs in it follow the cell inputs of that cycle, not of the
    // cycle in which software reads the data.

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff.phase <= PH_IDLE;
            st_ff.wr <= 1'b0;
            st_ff.addr <= 8'h00;
            st_ff.rdata <= 32'h0000_0000;
            st_ff.ctrl <= CTRL_RST;
            st_ff.slots <= SLOTS_RST;
            st_ff.pin_ctrl <= PIN_RST;
            st_ff.cell_cfg <= {NUM_CELLS{CELL_RST}};
            st_ff.q <= 8'h00;
            st_ff.clk_prev <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule
`default_nettype wire

//--- logic_tile_assertions.sv
/* Concurrent checks on the logic tile ports: bus timing and pin state.
   Assumes one hclk domain and a single bus slave, hready = hreadyout. */
`timescale 1ns/1ps
`default_nettype none
module logic_tile_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic [7:0] global_pin_out,
    input wire logic [7:0] global_pin_oe_n,
    input wire logic io_float_control
);
    // One domain, so clock and reset are given once
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Bus answers: one wait cycle, then ready, never an error
    a_resp_okay: assert property (hresp == 1'b0) else $error("error response seen");
    a_wait_one: assert property (hsel && htrans[1] && hready && hreadyout
        |=> !hreadyout ##1 hreadyout) else $error("transfer not two cycles");
    a_ready_idle: assert property (!(hsel && htrans[1]) && hreadyout |=> hreadyout)
        else $error("wait without transfer");
    a_rdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
        else $error("read data moved while ready");
    // Pins only change when a register write lands
    a_float_oe: assert property (io_float_control |-> global_pin_oe_n == 8'hff)
        else $error("pin driven during configuration");
    a_float_write: assert property ($changed(io_float_control) |-> !$past(hreadyout))
        else $error("configuration state changed without write");
    a_pinout_write: assert property ($changed(global_pin_out) |-> !$past(hreadyout))
        else $error("pin value changed without write");
    a_oe_write: assert property ($changed(global_pin_oe_n) |-> !$past(hreadyout))
        else $error("pin enable changed without write");
endmodule
bind logic_tile logic_tile_checker i_logic_tile_checker (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .htrans(htrans), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .global_pin_out(global_pin_out), .global_pin_oe_n(global_pin_oe_n),
    .io_float_control(io_float_control));
`default_nettype wire

//--- tile_neighbours.sv
/* Model of the tile's neighbours: eight global buffers and a fabric clock.
   Assumes the bench calls its tasks; all changes land after hclk edges. */
`timescale 1ns/1ps
`default_nettype none
module tile_neighbours (
    input wire logic hclk,
    output logic [7:0] global_drive_buffer,
    output logic fabric_clk
);
    // Fabric clock rests low outside pulses; buffers hold levels
    initial begin
        global_drive_buffer = 8'h00;
        fabric_clk = 1'b0;
    end
    // Level of one buffer, used as enable or set/reset source
    task automatic set_buf(input int idx, input logic val);
        @(posedge hclk);
        global_drive_buffer[idx] <= val;
    endtask
    // One rising edge on a source (8 is fabric), high for two samples
    task automatic pulse(input int idx);
        @(posedge hclk);
        if (idx == 8) fabric_clk <= 1'b1;
        else global_drive_buffer[idx] <= 1'b1;
        repeat (2) @(posedge hclk);
        if (idx == 8) fabric_clk <= 1'b0;
        else global_drive_buffer[idx] <= 1'b0;
        repeat (3) @(posedge hclk);
    endtask
endmodule
`default_nettype wire

//--- programmable_logic_tile_bench.sv
/* Self-checking bench of the logic tile over its bus and cell ports.
   Assumes the tile answers every transfer with one wait cycle. */
`timescale 1ns/1ps
`default_nettype none
module programmable_logic_tile_bench;
    import tile_pkg::*;
    logic hclk, hreadyout, hresp, cco, fclk, float_ctl;
    logic hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, cin = 1'b0, fce = 1'b0, fsr = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, cdata = 32'h0, hrdata;
    logic [7:0] pin_in, pin_out, oe_n, cell_out;
    int err_total = 0, cmp_count = 0, cyc = 0;
    logic_tile i_logic_tile (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .global_input_pin(pin_in),
        .global_pin_out(pin_out), .global_pin_oe_n(oe_n), .io_float_control(float_ctl),
        .fabric_clk(fclk), .fabric_ce(fce), .fabric_sr(fsr), .cell_data_in(cdata),
        .carry_chain_input(cin), .carry_chain_output(cco), .cell_out(cell_out));
    tile_neighbours i_tile_neighbours (.hclk(hclk), .global_drive_buffer(pin_in), .fabric_clk(fclk));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // Cut a hang short; the run needs well under a thousand cycles
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One single transfer: address phase, then data phase, both held until ready
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, r);
        chk(nm, exp, r);
    endtask
    task automatic settle();
        @(posedge hclk);
        #1;
    endtask
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        rd_chk(OFS_TILE_CTRL, 32'h1, "tile_ctrl");
        wr(OFS_PIN_CTRL, 32'h3c5a);
        settle();
        chk("oe_config", 32'hff, 32'(oe_n));
        wr(OFS_TILE_CTRL, 32'h0);
        settle();
        chk("oe_run", 32'hc3, 32'(oe_n));
        chk("pin_out", 32'h5a, 32'(pin_out));
        rd_chk(8'h10, 32'h0, "unmapped");
        // Parity table walks all sixteen addresses
        wr(OFS_CELL_BASE, 32'h6996);
        for (int i = 0; i < 16; i++) begin
            cdata <= 32'(i);
            settle();
            chk("lookup", 32'(^i[3:0]), 32'(cell_out[0]));
        end
        // Every cell propagates carry when only i1 is high
        for (int c = 0; c < 2; c++) begin
            cdata <= 32'h22222222;
            cin <= c[0];
            settle();
            chk("carry", 32'(c), 32'(cco));
        end
        i_tile_neighbours.set_buf(0, 1'b1);
        wr(OFS_CELL_BASE + 8'h04, 32'h1ffff);
        wr(OFS_TILE_CTRL, 32'h400);
        i_tile_neighbours.pulse(8);
        chk("fabric_q", 32'h1, 32'(cell_out[1]));
        wr(OFS_CELL_BASE + 8'h04, 32'h10000);
        wr(OFS_TILE_CTRL, 32'h2908);
        settle();
        chk("oe_clock", 32'he3, 32'(oe_n));
        i_tile_neighbours.pulse(5);
        chk("ce_hold", 32'h1, 32'(cell_out[1]));
        i_tile_neighbours.set_buf(3, 1'b1);
        i_tile_neighbours.pulse(5);
        chk("ce_run", 32'h0, 32'(cell_out[1]));
        wr(OFS_CELL_BASE + 8'h04, 32'h1ffff);
        wr(OFS_TILE_CTRL, 32'h2804);
        i_tile_neighbours.pulse(5);
        chk("sync_reset", 32'h0, 32'(cell_out[1]));
        wr(OFS_CELL_BASE + 8'h04, 32'h9ffff);
        wr(OFS_TILE_CTRL, 32'h2806);
        repeat (3) settle();
        chk("async_set", 32'h1, 32'(cell_out[1]));
        wr(OFS_TILE_CTRL, 32'h2807);
        settle();
        chk("wake_q", 32'h0, 32'(cell_out[1]));
        chk("float", 32'h1, 32'(float_ctl));
        final_report();
    end
endmodule
`default_nettype wire
